// *** hw/frs_map.svh ***
// register command codes, field positions, reset values and codes for the fault retry sequencer
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH

// command codes of the registers held in this block
`define FRS_CMD_UV_REACTION 8'h45
`define FRS_CMD_OC_THRESHOLD 8'h46
`define FRS_CMD_OC_REACTION 8'h47
`define FRS_CMD_DELAY_UNIT 8'hD2

// field positions inside a reaction byte
`define FRS_MODE_MSB 7
`define FRS_MODE_LSB 6
`define FRS_RETRY_MSB 5
`define FRS_RETRY_LSB 3
`define FRS_DELAY_MSB 2
`define FRS_DELAY_LSB 0

// retry field codes
`define FRS_RETRY_NONE 3'h0
`define FRS_RETRY_ALWAYS 3'h7

// over-current response codes
`define FRS_OC_IGNORE 2'h0
`define FRS_OC_LV_LIMIT 2'h1
`define FRS_OC_DELAY 2'h2
`define FRS_OC_TRIP 2'h3

// under-voltage response code that shuts the output down
`define FRS_UV_DISABLE_RETRY 2'h2

// reset values
`define FRS_RST_OC_THRESHOLD 16'h0000
`define FRS_RST_OC_REACTION 8'h00
`define FRS_RST_UV_REACTION 8'h00
`define FRS_RST_DELAY_UNIT 16'h00C8
`define FRS_RST_RDATA 16'h0000

`endif

// *** hw/frs_pkg.sv ***
// types and helpers shared by the fault retry sequencer files
package frs_pkg;

   // sequencer states, gray coded along run -> limit -> wait -> latch
   typedef enum logic [2:0] {
      FRS_RUN = 3'b000,
      FRS_LIMIT = 3'b001,
      FRS_WAIT = 3'b011,
      FRS_LATCH = 3'b010,
      FRS_OFF = 3'b110
   } frs_state_t;

   // delay field value to number of delay units: two to the power of the field
   function automatic logic [7:0] frs_units(input logic [2:0] exp_val);
      frs_units = 8'h01 << exp_val;
   endfunction

endpackage

// *** hw/frs_delay_timer.sv ***
// delay timer counting a power-of-two number of delay units of programmable length
`timescale 1ns/1ps
module frs_delay_timer #(
   parameter int UNIT_W = 16
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [2:0] units_exp,
   input wire logic [UNIT_W-1:0] unit_len,
   output logic busy,
   output logic done
);
   import frs_pkg::*;

   logic [UNIT_W-1:0] pre;
   logic [UNIT_W-1:0] len_hold;
   logic [7:0] units;
   logic [2:0] exp_hold;
   int unsigned elapsed;

   // a zero unit length would stall forever, so it counts as one cycle
   wire logic [UNIT_W-1:0] len_m1 = (unit_len == '0) ? '0 : unit_len - 1'b1;
   wire logic [UNIT_W-1:0] hold_m1 = (len_hold == '0) ? '0 : len_hold - 1'b1;
   wire logic [7:0] units_m1 = frs_units(units_exp) - 8'h01;
   wire logic last_tick = busy && (pre == '0) && (units == 8'h00);

   ///////////////////////////////////////////////////////////////////////////
   // the unit length is captured at start so a later register write waits its turn
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy <= 1'b0;
         done <= 1'b0;
         pre <= '0;
         units <= 8'h00;
         len_hold <= '0;
         exp_hold <= 3'h0;
      end else if (start) begin
         busy <= 1'b1;
         done <= 1'b0;
         pre <= len_m1;
         units <= units_m1;
         len_hold <= unit_len;
         exp_hold <= units_exp;
      end else begin
         done <= last_tick;
         busy <= busy && !last_tick;
         if (busy && pre == '0) begin
            pre <= hold_m1;
            units <= units - 8'h01;
         end else if (busy) begin
            pre <= pre - 1'b1;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // cycles spent busy, watched only by the span check
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         elapsed <= 0;
      end else if (start) begin
         elapsed <= 0;
      end else if (busy) begin
         elapsed <= elapsed + 1;
      end
   end

   timer_span_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      done |-> elapsed == int'(frs_units(exp_hold)) * ((len_hold == '0) ? 1 : int'(len_hold)))
      else $error("delay span differs from units times unit length");

endmodule // frs_delay_timer

// *** hw/frs_sequencer.sv ***
// over-current and under-voltage fault response sequencer with its registers
`timescale 1ns/1ps
`include "frs_map.svh"

// Operation
// - retry codes two to six restart that often
// - code seven restarts until off or bias lost
// - restart spacing is delay count times unit; in mode two the hold runs first, so attempt starts lie one hold further apart
// - delay field gives two-power number of units
// - one delay count serves hold or spacing
// - unit length comes from its own register
// - sixteen bit over-current threshold, read and write
// - every over-current fault sets status and notifies
// - code zero keeps limiting current indefinitely
// - code one shuts down on low voltage
// - code two limits for delay, then retries
// - code three shuts down at once, then retries
// - retry code zero never restarts, stays off
// - reaction bits five to three count restarts
// - retry code one restarts exactly once
// - latched fault cleared by clear, reset, cycling
// - under-voltage code two disables then retries
module frs_sequencer #(
   parameter int UNIT_W = 16
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_cmd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   input wire logic oc_detect,
   input wire logic lv_detect,
   input wire logic uv_detect,
   input wire logic on_cmd,
   input wire logic bias_ok,
   input wire logic clear_faults,
   input wire logic clear_oc_bit,
   input wire logic clear_uv_bit,
   output logic out_enable,
   output logic cc_limit,
   output logic fault_latched,
   output logic [15:0] oc_threshold,
   output logic oc_fault_status,
   output logic uv_fault_status,
   output logic alert
);
   import frs_pkg::*;

   frs_state_t state;
   frs_state_t next_state;
   logic [7:0] oc_reaction;
   logic [7:0] uv_reaction;
   logic [UNIT_W-1:0] delay_unit;
   logic [7:0] snap_resp;
   logic [2:0] retries_left;
   logic budget_loaded;
   logic power_q;
   logic timer_busy;
   logic timer_done;

   ///////////////////////////////////////////////////////////////////////////
   // register decode
   wire logic wr_thr = reg_wr && (reg_cmd == `FRS_CMD_OC_THRESHOLD);
   wire logic wr_ocr = reg_wr && (reg_cmd == `FRS_CMD_OC_REACTION);
   wire logic wr_uvr = reg_wr && (reg_cmd == `FRS_CMD_UV_REACTION);
   wire logic wr_unit = reg_wr && (reg_cmd == `FRS_CMD_DELAY_UNIT);
   // unmapped codes read as zero and ignore writes
   wire logic [15:0] next_rdata =
      (reg_cmd == `FRS_CMD_OC_THRESHOLD) ? oc_threshold :
      (reg_cmd == `FRS_CMD_OC_REACTION) ? {8'h00, oc_reaction} :
      (reg_cmd == `FRS_CMD_UV_REACTION) ? {8'h00, uv_reaction} :
      (reg_cmd == `FRS_CMD_DELAY_UNIT) ? 16'(delay_unit) : 16'h0000;

   ///////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         oc_threshold <= `FRS_RST_OC_THRESHOLD;
         oc_reaction <= `FRS_RST_OC_REACTION;
         uv_reaction <= `FRS_RST_UV_REACTION;
         delay_unit <= UNIT_W'(`FRS_RST_DELAY_UNIT);
      end else begin
         if (wr_thr) oc_threshold <= reg_wdata;
         if (wr_ocr) oc_reaction <= reg_wdata[7:0];
         if (wr_uvr) uv_reaction <= reg_wdata[7:0];
         if (wr_unit) delay_unit <= UNIT_W'(reg_wdata);
      end
   end

   // read data and acknowledge, one cycle after the strobe
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= `FRS_RST_RDATA;
         reg_ack <= 1'b0;
      end else begin
         reg_ack <= reg_wr || reg_rd;
         if (reg_rd) reg_rdata <= next_rdata;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // power, clear and detection terms
   wire logic power_ok = on_cmd && bias_ok;
   wire logic fresh_on = power_ok && !power_q;
   wire logic latch_clear = clear_faults || clear_oc_bit || clear_uv_bit || fresh_on;
   wire logic running = (state == FRS_RUN) || (state == FRS_LIMIT);
   wire logic oc_hit = (state == FRS_RUN) && oc_detect;
   wire logic [1:0] live_mode = oc_reaction[`FRS_MODE_MSB:`FRS_MODE_LSB];
   wire logic [1:0] snap_mode = snap_resp[`FRS_MODE_MSB:`FRS_MODE_LSB];
   wire logic uv_shut = (state == FRS_RUN) && !oc_detect && uv_detect &&
      (uv_reaction[`FRS_MODE_MSB:`FRS_MODE_LSB] == `FRS_UV_DISABLE_RETRY);
   // the byte of the fault being detected now, else the one captured at detection
   wire logic [7:0] live_resp = oc_hit ? oc_reaction : uv_reaction;
   wire logic [7:0] act_resp = (state == FRS_RUN) ? live_resp : snap_resp;

   // shutdown causes per response mode
   wire logic trip_now = oc_hit && (live_mode == `FRS_OC_TRIP);
   wire logic lv_trip = (state == FRS_LIMIT) && oc_detect && lv_detect &&
      (snap_mode == `FRS_OC_LV_LIMIT);
   wire logic delay_trip = (state == FRS_LIMIT) && oc_detect && timer_done &&
      (snap_mode == `FRS_OC_DELAY);
   wire logic shut_now = trip_now || uv_shut || lv_trip || delay_trip;
   wire logic enter_limit = oc_hit && (live_mode != `FRS_OC_TRIP);

   // retry budget, taken fresh from the reaction byte after every reload
   wire logic [2:0] budget = budget_loaded ? retries_left :
      act_resp[`FRS_RETRY_MSB:`FRS_RETRY_LSB];
   wire logic can_retry = (budget != `FRS_RETRY_NONE);
   wire logic restart = (state == FRS_WAIT) && power_ok && !timer_busy;

   // the timer runs for the hold in mode two, or the spacing between attempt starts
   wire logic hold_start = enter_limit && (live_mode == `FRS_OC_DELAY) && power_ok;
   wire logic wait_start = shut_now && can_retry && !timer_busy && power_ok;
   wire logic timer_start = hold_start || wait_start || restart;
   wire logic [2:0] timer_exp = (state == FRS_RUN) ? live_resp[`FRS_DELAY_MSB:`FRS_DELAY_LSB] :
      snap_resp[`FRS_DELAY_MSB:`FRS_DELAY_LSB];

   ///////////////////////////////////////////////////////////////////////////
   // one timer serves both uses; in mode two the hold after a restart cuts short the spacing run that restart began
   frs_delay_timer #(
      .UNIT_W(UNIT_W)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .start(timer_start),
      .units_exp(timer_exp),
      .unit_len(delay_unit),
      .busy(timer_busy),
      .done(timer_done)
   );

   ///////////////////////////////////////////////////////////////////////////
   // next state; losing power or the on command outranks every fault step
   always_comb begin
      next_state = state;
      if (!power_ok) begin
         next_state = FRS_OFF;
      end else begin
         case (state)
            FRS_RUN: begin
               if (shut_now) next_state = can_retry ? FRS_WAIT : FRS_LATCH;
               else if (enter_limit) next_state = FRS_LIMIT;
            end
            FRS_LIMIT: begin
               if (shut_now) next_state = can_retry ? FRS_WAIT : FRS_LATCH;
               else if (!oc_detect) next_state = FRS_RUN;
            end
            FRS_WAIT: begin
               if (restart) next_state = FRS_RUN;
            end
            FRS_LATCH: begin
               if (latch_clear) next_state = FRS_RUN;
            end
            FRS_OFF: begin
               next_state = FRS_RUN;
            end
            default: begin
               next_state = FRS_OFF;
            end
         endcase
      end
   end

   // state and the outputs that follow it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= FRS_OFF;
         out_enable <= 1'b0;
         cc_limit <= 1'b0;
         fault_latched <= 1'b0;
         power_q <= 1'b0;
      end else begin
         state <= next_state;
         out_enable <= (next_state == FRS_RUN) || (next_state == FRS_LIMIT);
         cc_limit <= (next_state == FRS_LIMIT);
         fault_latched <= (next_state == FRS_LATCH);
         power_q <= power_ok;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // response capture at detection, so a write mid-sequence waits for the next fault
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         snap_resp <= `FRS_RST_OC_REACTION;
      end else if (state == FRS_RUN && (oc_detect || uv_shut)) begin
         snap_resp <= live_resp;
      end
   end

   // remaining restarts; code seven never counts down
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         retries_left <= `FRS_RETRY_NONE;
         budget_loaded <= 1'b0;
      end else if (fresh_on || latch_clear || !power_ok) begin
         budget_loaded <= 1'b0;
      end else if (shut_now && can_retry) begin
         retries_left <= budget;
         budget_loaded <= 1'b1;
      end else if (restart && retries_left != `FRS_RETRY_ALWAYS) begin
         retries_left <= retries_left - 3'h1;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // sticky status bits: a new fault in the clearing cycle still sets
   wire logic oc_set = running && oc_detect;
   wire logic uv_set = running && uv_detect;
   wire logic oc_clr = clear_faults || clear_oc_bit || fresh_on || !bias_ok;
   wire logic uv_clr = clear_faults || clear_uv_bit || fresh_on || !bias_ok;
   wire logic next_oc_stat = oc_set || (oc_fault_status && !oc_clr);
   wire logic next_uv_stat = uv_set || (uv_fault_status && !uv_clr);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         oc_fault_status <= 1'b0;
         uv_fault_status <= 1'b0;
         alert <= 1'b0;
      end else begin
         oc_fault_status <= next_oc_stat;
         uv_fault_status <= next_uv_stat;
         alert <= next_oc_stat || next_uv_stat;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // checks
   default clocking chk_clk @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   thr_write_a: assert property (wr_thr |=> oc_threshold == $past(reg_wdata))
      else $error("threshold write lost");
   oc_status_a: assert property (oc_set |=> oc_fault_status && alert)
      else $error("over-current did not set status");
   ignore_hold_a: assert property (state == FRS_LIMIT && snap_mode == `FRS_OC_IGNORE &&
      oc_detect && power_ok |=> cc_limit && out_enable) else $error("limit dropped");
   lv_trip_a: assert property (lv_trip && power_ok |=> !out_enable)
      else $error("low voltage did not shut down");
   delay_trip_a: assert property (hold_start |=> timer_busy && cc_limit)
      else $error("hold timer not running");
   hard_trip_a: assert property (trip_now && power_ok |=> !out_enable && !cc_limit)
      else $error("trip code did not shut down");
   never_retry_a: assert property (state == FRS_LATCH && power_ok && !latch_clear
      |=> state == FRS_LATCH && !out_enable) else $error("latched output restarted");
   retry_count_a: assert property (restart && budget_loaded &&
      retries_left != `FRS_RETRY_ALWAYS && !latch_clear |=>
      retries_left == $past(retries_left) - 3'h1) else $error("retry count not stepped");
   retry_always_a: assert property (restart && retries_left == `FRS_RETRY_ALWAYS &&
      !latch_clear |=> retries_left == `FRS_RETRY_ALWAYS) else $error("continuous count moved");
   uv_trip_a: assert property (uv_shut && power_ok |=> !out_enable)
      else $error("under-voltage did not shut down");
   latch_clear_a: assert property (state == FRS_LATCH && clear_faults && power_ok
      |=> state == FRS_RUN && out_enable) else $error("clear did not restart");
   budget_reload_a: assert property (fresh_on |=> !budget_loaded)
      else $error("budget not reloaded");
   snap_hold_a: assert property (state == FRS_LIMIT && $past(state) == FRS_LIMIT
      |-> $stable(snap_resp)) else $error("reaction changed mid-sequence");
   // the spacing timer gates every restart, so a busy timer keeps the output off
   restart_gap_a: assert property (state == FRS_WAIT && timer_busy |=> !out_enable)
      else $error("restart before spacing elapsed");
   hold_keep_a: assert property (state == FRS_LIMIT && snap_mode == `FRS_OC_DELAY &&
      timer_busy && oc_detect && power_ok |=> cc_limit) else $error("hold ended early");
   budget_load_a: assert property (shut_now && can_retry && !budget_loaded &&
      power_ok && !latch_clear |=>
      retries_left == $past(act_resp[`FRS_RETRY_MSB:`FRS_RETRY_LSB]))
      else $error("retry budget not taken from reaction");
   once_retry_a: assert property (restart && budget_loaded &&
      retries_left == 3'h1 && !latch_clear |=> retries_left == 3'h0)
      else $error("single retry not spent");
   // the on command and bias outrank every fault step, and clears only lose to a new set
   power_off_a: assert property (!power_ok |=> !out_enable && !cc_limit)
      else $error("output stayed on without power");
   oc_clear_a: assert property (clear_oc_bit && !oc_set |=> !oc_fault_status)
      else $error("over-current status not cleared");
   uv_clear_a: assert property (clear_uv_bit && !uv_set |=> !uv_fault_status)
      else $error("under-voltage status not cleared");
   unit_write_a: assert property (wr_unit |=>
      delay_unit == UNIT_W'($past(reg_wdata))) else $error("delay unit write lost");

endmodule // frs_sequencer

// *** tb/frs_host.sv ***
// host model issuing register requests and clear commands to the sequencer
`timescale 1ns/1ps
module frs_host (
   input wire logic sys_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_cmd,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   output logic clear_faults
);
   // idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_cmd = 8'h00;
      reg_wdata = 16'h0000;
      clear_faults = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one-cycle strobe, then the answer is taken with the ack one cycle later;
   // released lines show the inverse so a stale command is never reused
   task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] data,
                       output logic [15:0] rdata, output logic acked);
      @(negedge sys_clk);
      reg_wr <= wr;
      reg_rd <= ~wr;
      reg_cmd <= cmd;
      reg_wdata <= data;
      @(negedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_cmd <= ~cmd;
      reg_wdata <= ~data;
      acked = reg_ack;
      rdata = reg_rdata;
   endtask

   // clear-all command pulse
   task automatic clear_all();
      @(negedge sys_clk);
      clear_faults <= 1'b1;
      @(negedge sys_clk);
      clear_faults <= 1'b0;
   endtask
endmodule // frs_host

// *** tb/tb.sv ***
// self-checking bench for the fault retry sequencer
`timescale 1ns/1ps
module tb;
   logic sys_clk, rst_b, reg_wr, reg_rd, reg_ack, oc_detect, lv_detect, uv_detect, on_cmd;
   logic bias_ok, clear_faults, clear_oc_bit, clear_uv_bit, out_enable, cc_limit;
   logic fault_latched, oc_fault_status, uv_fault_status, alert, prev_en;
   logic [7:0] reg_cmd;
   logic [15:0] reg_wdata, reg_rdata, oc_threshold;
   logic [7:0] retry_react [3] = '{8'hC8, 8'hD2, 8'hF0};
   int retry_exp [3] = '{1, 2, 6};
   int bad_count = 0, n_checks = 0, cyc = 0, rises = 0, last_rise = 0, gap = 0, hold = 0;

   frs_sequencer frs_sequencer_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .oc_detect(oc_detect), .lv_detect(lv_detect), .uv_detect(uv_detect),
      .on_cmd(on_cmd), .bias_ok(bias_ok), .clear_faults(clear_faults),
      .clear_oc_bit(clear_oc_bit), .clear_uv_bit(clear_uv_bit), .out_enable(out_enable),
      .cc_limit(cc_limit), .fault_latched(fault_latched), .oc_threshold(oc_threshold),
      .oc_fault_status(oc_fault_status), .uv_fault_status(uv_fault_status), .alert(alert));
   frs_host frs_host_i (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .clear_faults(clear_faults));

   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // restart counter and spacing monitor; the ceiling cuts a hung sequence short
   always @(posedge sys_clk) begin
      cyc++;
      if (out_enable === 1'b1 && prev_en !== 1'b1) begin
         gap = cyc - last_rise;
         last_rise = cyc;
         rises++;
      end
      prev_en = out_enable;
      if (cyc > 20000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // register access and sequence helpers
   task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
      logic [15:0] data;
      logic acked;
      frs_host_i.xfer(1'b0, cmd, 16'h0000, data, acked);
      check(16'(acked), 16'h0001, "read ack");
      check(data, exp, "read data");
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
      logic [15:0] unused;
      logic acked;
      frs_host_i.xfer(1'b1, cmd, data, unused, acked);
      check(16'(acked), 16'h0001, "write ack");
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // back to a clean running output, then raise the over-current cause
   task automatic fault(input logic [7:0] react);
      @(negedge sys_clk);
      oc_detect = 1'b0;
      lv_detect = 1'b0;
      uv_detect = 1'b0;
      on_cmd = 1'b1;
      frs_host_i.clear_all();
      wr(8'h47, {8'h00, react});
      cycles(3);
      rises = 0;
      oc_detect = 1'b1;
   endtask

   task automatic wait_latch();
      for (int i = 0; i < 900 && fault_latched !== 1'b1; i++) begin
         @(negedge sys_clk);
      end
      check(16'(fault_latched), 16'h0001, "latched");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {rst_b, oc_detect, lv_detect, uv_detect, clear_oc_bit, clear_uv_bit} = '0;
      {on_cmd, bias_ok} = 2'b11;
      cycles(5);
      rst_b = 1'b1;
      cycles(2);
      rd(8'h46, 16'h0000);
      rd(8'h47, 16'h0000);
      rd(8'h45, 16'h0000);
      rd(8'hD2, 16'h00C8);
      rd(8'h99, 16'h0000);
      wr(8'h46, 16'hA5C3);
      rd(8'h46, 16'hA5C3);
      check(oc_threshold, 16'hA5C3, "threshold port");
      wr(8'hD2, 16'h0001);
      $display("test registers done");
      // immediate trip without retry, cleared by the single status bit
      fault(8'hC0);
      cycles(1);
      check(16'({out_enable, fault_latched}), 16'h0001, "trip");
      check(16'({oc_fault_status, alert}), 16'h0003, "status");
      oc_detect = 1'b0;
      cycles(5);
      check(16'(fault_latched), 16'h0001, "stays off");
      clear_oc_bit = 1'b1;
      cycles(1);
      clear_oc_bit = 1'b0;
      cycles(2);
      check(16'({out_enable, fault_latched, oc_fault_status}), 16'h0004, "cleared");
      $display("test trip done");
      // bounded retries; the middle run is reprogrammed in mid-sequence
      for (int k = 0; k < 3; k++) begin
         fault(retry_react[k]);
         if (k == 1) begin
            while (rises < 1 && cyc < 19000) @(negedge sys_clk);
            wr(8'h47, 16'h00C0);
         end
         wait_latch();
         check(16'(rises), 16'(retry_exp[k]), "restarts");
      end
      $display("test retry count done");
      // continuous retry keeps going until the off command stops it
      fault(8'hF8);
      cycles(100);
      check(16'(rises > 20), 16'h0001, "endless");
      check(16'(fault_latched), 16'h0000, "endless unlatched");
      on_cmd = 1'b0;
      cycles(2);
      hold = rises;
      cycles(20);
      check(16'(out_enable), 16'h0000, "off stops");
      check(16'(rises - hold), 16'h0000, "off no restart");
      $display("test continuous done");
      // spacing of restarts for delay fields 0..3 with a two-cycle unit
      wr(8'hD2, 16'h0002);
      for (int f = 0; f < 4; f++) begin
         fault(8'hD0 | 8'(f));
         wait_latch();
         check(16'(gap >= (2 << f) && gap <= (2 << f) + 2), 16'h0001, "spacing");
      end
      $display("test spacing done");
      // timed limiting: expiry shuts down, early recovery returns to run
      fault(8'h82);
      hold = 0;
      while (fault_latched !== 1'b1 && hold < 100) begin
         @(negedge sys_clk);
         if (cc_limit === 1'b1) hold++;
      end
      check(16'(hold >= 8 && hold <= 10), 16'h0001, "hold time");
      fault(8'h87);
      cycles(3);
      oc_detect = 1'b0;
      cycles(3);
      check(16'({out_enable, cc_limit, fault_latched}), 16'h0004, "recovered");
      // indefinite limiting
      fault(8'h00);
      cycles(40);
      check(16'({out_enable, cc_limit, fault_latched, oc_fault_status}), 16'h000D,
         "ignore");
      // limiting until the voltage drops
      fault(8'h40);
      cycles(10);
      check(16'({out_enable, cc_limit}), 16'h0003, "lv limit");
      lv_detect = 1'b1;
      cycles(1);
      check(16'({out_enable, fault_latched}), 16'h0001, "lv trip");
      $display("test modes done");
      // under-voltage disable, cleared by its own status bit
      fault(8'h00);
      oc_detect = 1'b0;
      wr(8'h45, 16'h0080);
      uv_detect = 1'b1;
      cycles(1);
      check(16'({out_enable, fault_latched, uv_fault_status, alert}), 16'h0007, "uv");
      uv_detect = 1'b0;
      clear_uv_bit = 1'b1;
      cycles(1);
      clear_uv_bit = 1'b0;
      cycles(2);
      check(16'({out_enable, fault_latched, uv_fault_status}), 16'h0004, "uv clear");
      bias_ok = 1'b0;
      cycles(2);
      check(16'(out_enable), 16'h0000, "bias lost");
      $display("test under-voltage done");
      finish_test();
   end
endmodule // tb
